// ### hw/cal_regs.svh
// constants for the chip-select-to-command latency front end
// assumes one shared clock at 200 MHz for controller and device
`ifndef CAL_REGS_SVH
`define CAL_REGS_SVH

`define CMD_W                 4
`define ADDR_W                17
`define CMD_MODE_WRITE        4'h8
`define CMD_READ              4'hd
`define CMD_DESELECT          4'hf
`define MR_SEL_ZERO           4'h0
`define MR_SEL_ONE            4'h1
`define CAL_LSB               6
`define CAL_W                 3
`define CAL_PIPE_D            7
`define BL_LSB                0
`define BL_W                  2
`define BL_FIXED8             2'h0
`define BL_ON_THE_FLY         2'h1
`define BL_OTF_BIT            12
`define WAIT_W                6
`define CLK_PERIOD_PS         5000
`define CS_TO_CMD_DELAY_TIME_PS     15000
`define MODE_SET_UPDATE_DELAY_PS    15000
`define MODE_SET_CYCLE_DELAY_PS     40000

`endif

// ### hw/cal_pkg.sv
// types and helpers shared by both ends of the command link
// assumes cal_regs.svh is compiled ahead of it
`include "cal_regs.svh"
package cal_pkg;
   typedef logic [`CMD_W-1:0]  cmd_t;
   typedef logic [`ADDR_W-1:0] addr_t;
   typedef logic [`CAL_W-1:0]  cal_t;
   typedef logic [`WAIT_W-1:0] wait_t;

   typedef enum logic [1:0]
   {
      CTL_IDLE   = 2'h0,
      CTL_SELECT = 2'h1,
      CTL_ISSUE  = 2'h3
   } ctl_state_t;

   // least time in picoseconds to whole clocks, rounded up
   function automatic wait_t cycles_up(input int ps);
      int c;
      c = (ps + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
      if (c < 1)
      begin
         c = 1;
      end
      return wait_t'(c);
   endfunction
endpackage

// ### hw/cal_link_if.sv
// command/address link between controller and memory device
// assumes both ends share one clock; no clocking block
`timescale 1ns/1ps
interface cal_link_if;
   logic                cs_b;
   cal_pkg::cmd_t       cmd;
   cal_pkg::addr_t      addr;
   logic [1:0]          bank;
   logic [1:0]          group;
   logic                odt;

   modport controller
   (
      output cs_b, cmd, addr, bank, group, odt
   );
   modport device
   (
      input  cs_b, cmd, addr, bank, group, odt
   );
endinterface

// ### hw/cs_delay_pipe.sv
// chip-select-low history; marks the cycle a command is due
// assumes cs_low is a same-clock registered pin sample
`timescale 1ns/1ps
`include "cal_regs.svh"
module cs_delay_pipe
(
   input  wire logic           clock,
   input  wire logic           rst_b,
   input  wire logic           cs_low,
   input  wire cal_pkg::cal_t  cal,
   output logic                due,
   output logic                pending
);
   logic [`CAL_PIPE_D-1:0] pipe_reg;
   logic [`CAL_PIPE_D-1:0] pipe_next;

   always_comb
   begin
      pipe_next = {pipe_reg[`CAL_PIPE_D-2:0], cs_low};
      if (cal == '0)
      begin
         // no history with the latency off, so no replay when it turns on
         pipe_next = '0;
         due     = cs_low;
         pending = 1'b0;
      end
      else
      begin
         due     = pipe_reg[cal - 3'h1];
         pending = cs_low;
         for (int i = 0; i < `CAL_PIPE_D; i++)
         begin
            if (i < int'(cal) - 1 && pipe_reg[i])
            begin
               pending = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pipe_reg <= '0;
      end
      else
      begin
         pipe_reg <= pipe_next;
      end
   end
endmodule // cs_delay_pipe

// ### hw/cal_device.sv
// device end: delayed command capture and receiver power control
// assumes the link shares this clock; pins are sampled in-domain
`timescale 1ns/1ps
`include "cal_regs.svh"
module cal_device
(
   input  wire logic              clock,
   input  wire logic              rst_b,
   cal_link_if.device             link,
   output logic                   cmd_valid,
   output cal_pkg::cmd_t          cmd_out,
   output cal_pkg::addr_t         addr_out,
   output logic [3:0]             mode_sel_out,
   output logic                   rx_enable,
   output cal_pkg::cal_t          cal_value,
   output logic                   cal_active,
   output logic [`BL_W-1:0]       burst_field,
   output logic                   read_burst_of_eight,
   output logic                   odt_out
);
   logic                  due;
   logic                  pending;
   logic                  cs_low;
   logic [3:0]            sel;

   logic                  cmd_valid_reg;
   logic                  cmd_valid_next;
   cal_pkg::cmd_t         cmd_reg;
   cal_pkg::cmd_t         cmd_next;
   cal_pkg::addr_t        addr_reg;
   cal_pkg::addr_t        addr_next;
   logic [3:0]            sel_reg;
   logic [3:0]            sel_next;
   logic                  rx_reg;
   logic                  rx_next;
   cal_pkg::cal_t         cal_reg;
   cal_pkg::cal_t         cal_next;
   logic [`BL_W-1:0]      bl_reg;
   logic [`BL_W-1:0]      bl_next;
   logic                  bl8_reg;
   logic                  bl8_next;
   logic                  odt_reg;
   logic                  odt_next;
   logic                  cal_on_reg;
   logic                  cal_on_next;

   assign cs_low = ~link.cs_b;
   assign sel    = {link.group, link.bank};

   cs_delay_pipe u_pipe
   (
      .clock   (clock),
      .rst_b   (rst_b),
      .cs_low  (cs_low),
      .cal     (cal_reg),
      .due     (due),
      .pending (pending)
   );

   always_comb
   begin
      cmd_valid_next = due;
      cmd_next       = cmd_reg;
      addr_next      = addr_reg;
      sel_next       = sel_reg;
      cal_next       = cal_reg;
      bl_next        = bl_reg;
      bl8_next       = 1'b0;
      // receivers on from select sample through the last capture
      rx_next        = cs_low | pending;
      odt_next       = link.odt;
      if (due)
      begin
         cmd_next  = link.cmd;
         addr_next = link.addr;
         sel_next  = sel;
         if (link.cmd == `CMD_MODE_WRITE)
         begin
            if (sel == `MR_SEL_ONE)
            begin
               cal_next = link.addr[`CAL_LSB +: `CAL_W];
            end
            if (sel == `MR_SEL_ZERO)
            begin
               bl_next = link.addr[`BL_LSB +: `BL_W];
            end
         end
         if (link.cmd == `CMD_READ)
         begin
            bl8_next = (bl_reg == `BL_FIXED8) ||
                       (bl_reg == `BL_ON_THE_FLY &&
                        link.addr[`BL_OTF_BIT]);
         end
      end
      cal_on_next    = (cal_next != '0);
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cmd_valid_reg <= 1'b0;
         cmd_reg       <= `CMD_DESELECT;
         addr_reg      <= '0;
         sel_reg       <= '0;
         rx_reg        <= 1'b0;
         cal_reg       <= '0;
         bl_reg        <= `BL_FIXED8;
         bl8_reg       <= 1'b0;
         odt_reg       <= 1'b0;
         cal_on_reg    <= 1'b0;
      end
      else
      begin
         cmd_valid_reg <= cmd_valid_next;
         cmd_reg       <= cmd_next;
         addr_reg      <= addr_next;
         sel_reg       <= sel_next;
         rx_reg        <= rx_next;
         cal_reg       <= cal_next;
         bl_reg        <= bl_next;
         bl8_reg       <= bl8_next;
         odt_reg       <= odt_next;
         cal_on_reg    <= cal_on_next;
      end
   end

   assign cmd_valid           = cmd_valid_reg;
   assign cmd_out             = cmd_reg;
   assign addr_out            = addr_reg;
   assign mode_sel_out        = sel_reg;
   assign rx_enable           = rx_reg;
   assign cal_value           = cal_reg;
   assign cal_active          = cal_on_reg;
   assign burst_field         = bl_reg;
   assign read_burst_of_eight = bl8_reg;
   assign odt_out             = odt_reg;
endmodule // cal_device

// ### hw/cal_controller.sv
// controller end: selects, delays command, keeps mode-write gaps
// assumes one request at a time from the user side
`timescale 1ns/1ps
`include "cal_regs.svh"
module cal_controller
(
   input  wire logic              clock,
   input  wire logic              rst_b,
   cal_link_if.controller         link,
   input  wire logic              req_valid,
   input  wire cal_pkg::cmd_t     req_cmd,
   input  wire cal_pkg::addr_t    req_addr,
   input  wire logic [3:0]        req_sel,
   input  wire logic              req_cal_on,
   input  wire logic              req_odt,
   output logic                   req_ready,
   output cal_pkg::cal_t          cal_in_use
);
   localparam cal_pkg::wait_t CAL_CYC =
      cal_pkg::cycles_up(`CS_TO_CMD_DELAY_TIME_PS);
   localparam cal_pkg::wait_t UPD_CYC =
      cal_pkg::cycles_up(`MODE_SET_UPDATE_DELAY_PS);
   localparam cal_pkg::wait_t MRD_CYC =
      cal_pkg::cycles_up(`MODE_SET_CYCLE_DELAY_PS);

   // step a wait counter towards zero, holding at zero
   function automatic cal_pkg::wait_t count_down(input cal_pkg::wait_t v);
      return (v == '0) ? '0 : v - 6'h1;
   endfunction

   // extended gap after a mode write, from the new latency
   function automatic cal_pkg::wait_t gap_after(input cal_pkg::cal_t c);
      return UPD_CYC + {3'h0, c};
   endfunction

   cal_pkg::ctl_state_t   st_reg;
   cal_pkg::ctl_state_t   st_next;
   cal_pkg::cmd_t         hcmd_reg;
   cal_pkg::cmd_t         hcmd_next;
   cal_pkg::addr_t        haddr_reg;
   cal_pkg::addr_t        haddr_next;
   logic [3:0]            hsel_reg;
   logic [3:0]            hsel_next;
   cal_pkg::cal_t         cal_reg;
   cal_pkg::cal_t         cal_next;
   cal_pkg::wait_t        cnt_reg;
   cal_pkg::wait_t        cnt_next;
   cal_pkg::wait_t        any_reg;
   cal_pkg::wait_t        any_next;
   cal_pkg::wait_t        mrs_reg;
   cal_pkg::wait_t        mrs_next;
   logic                  cs_b_reg;
   logic                  cs_b_next;
   cal_pkg::cmd_t         cmd_reg;
   cal_pkg::cmd_t         cmd_next;
   cal_pkg::addr_t        addr_reg;
   cal_pkg::addr_t        addr_next;
   logic [3:0]            sel_reg;
   logic [3:0]            sel_next;
   logic                  odt_reg;
   logic                  odt_next;
   logic                  rdy_reg;
   logic                  rdy_next;
   logic                  gap_ok;
   logic                  is_mrs;
   cal_pkg::cal_t         new_cal;

   assign is_mrs = (req_cmd == `CMD_MODE_WRITE);
   assign gap_ok = is_mrs ? (mrs_reg == '0) : (any_reg == '0);

   always_comb
   begin
      st_next    = st_reg;
      hcmd_next  = hcmd_reg;
      haddr_next = haddr_reg;
      hsel_next  = hsel_reg;
      cal_next   = cal_reg;
      cnt_next   = count_down(cnt_reg);
      any_next   = count_down(any_reg);
      mrs_next   = count_down(mrs_reg);
      cs_b_next  = 1'b1;
      cmd_next   = `CMD_DESELECT;
      addr_next  = addr_reg;
      sel_next   = sel_reg;
      rdy_next   = 1'b0;
      new_cal    = req_cal_on ? CAL_CYC[`CAL_W-1:0] : '0;
      odt_next   = req_odt;
      unique case (st_reg)
         cal_pkg::CTL_IDLE:
         begin
            rdy_next = 1'b1;
            // gaps after a mode write hold the request back
            if (req_valid && rdy_reg && gap_ok)
            begin
               rdy_next   = 1'b0;
               hcmd_next  = req_cmd;
               haddr_next = req_addr;
               hsel_next  = req_sel;
               // the latency field is filled in here, not by the user
               if (is_mrs && req_sel == `MR_SEL_ONE)
               begin
                  haddr_next[`CAL_LSB +: `CAL_W] = new_cal;
               end
               cs_b_next = 1'b0;
               cnt_next  = {3'h0, cal_reg};
               st_next   = cal_pkg::CTL_SELECT;
               // zero latency: command goes with its select
               if (cal_reg == '0)
               begin
                  cmd_next  = req_cmd;
                  addr_next = haddr_next;
                  sel_next  = req_sel;
                  st_next   = cal_pkg::CTL_ISSUE;
               end
            end
         end
         cal_pkg::CTL_SELECT:
         begin
            // command leaves on the last latency cycle
            if (cnt_reg == 6'h1)
            begin
               cmd_next  = hcmd_reg;
               addr_next = haddr_reg;
               sel_next  = hsel_reg;
               st_next   = cal_pkg::CTL_ISSUE;
            end
         end
         cal_pkg::CTL_ISSUE:
         begin
            rdy_next = 1'b1;
            st_next  = cal_pkg::CTL_IDLE;
            // command wait uses the latency just written; mode-write wait does too, or MRD_CYC when old and new latency are both zero
            if (hcmd_reg == `CMD_MODE_WRITE)
            begin
               if (hsel_reg == `MR_SEL_ONE)
               begin
                  cal_next = haddr_reg[`CAL_LSB +: `CAL_W];
               end
               any_next = gap_after(cal_next);
               if (cal_reg != '0 || cal_next != '0)
               begin
                  mrs_next = gap_after(cal_next);
               end
               else
               begin
                  mrs_next = MRD_CYC;
               end
            end
         end
         default:
         begin
            st_next = cal_pkg::CTL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_reg    <= cal_pkg::CTL_IDLE;
         hcmd_reg  <= `CMD_DESELECT;
         haddr_reg <= '0;
         hsel_reg  <= '0;
         cal_reg   <= '0;
         cnt_reg   <= '0;
         any_reg   <= '0;
         mrs_reg   <= '0;
         cs_b_reg  <= 1'b1;
         cmd_reg   <= `CMD_DESELECT;
         addr_reg  <= '0;
         sel_reg   <= '0;
         odt_reg   <= 1'b0;
         rdy_reg   <= 1'b0;
      end
      else
      begin
         st_reg    <= st_next;
         hcmd_reg  <= hcmd_next;
         haddr_reg <= haddr_next;
         hsel_reg  <= hsel_next;
         cal_reg   <= cal_next;
         cnt_reg   <= cnt_next;
         any_reg   <= any_next;
         mrs_reg   <= mrs_next;
         cs_b_reg  <= cs_b_next;
         cmd_reg   <= cmd_next;
         addr_reg  <= addr_next;
         sel_reg   <= sel_next;
         odt_reg   <= odt_next;
         rdy_reg   <= rdy_next;
      end
   end

   // every link pin comes straight from a flop
   assign link.cs_b  = cs_b_reg;
   assign link.cmd   = cmd_reg;
   assign link.addr  = addr_reg;
   assign link.bank  = sel_reg[1:0];
   assign link.group = sel_reg[3:2];
   assign link.odt   = odt_reg;
   assign req_ready  = rdy_reg;
   assign cal_in_use = cal_reg;
endmodule // cal_controller

// ### testbench/cal_link_monitor.sv
// checker on the command link joining controller and device ends
// assumes one clock; sees only link signals, tracks latency itself
`timescale 1ns/1ps
`include "cal_regs.svh"
module cal_link_monitor
(
   input wire logic           clock,
   input wire logic           rst_b,
   input wire logic           cs_b,
   input wire cal_pkg::cmd_t  cmd,
   input wire cal_pkg::addr_t addr,
   input wire logic [1:0]     bank,
   input wire logic [1:0]     group,
   input wire logic           odt
);
   localparam int UPD = (`MODE_SET_UPDATE_DELAY_PS + `CLK_PERIOD_PS - 1)
      / `CLK_PERIOD_PS;
   localparam int MRD = (`MODE_SET_CYCLE_DELAY_PS + `CLK_PERIOD_PS - 1)
      / `CLK_PERIOD_PS;
   logic [6:0]    hist_reg;
   logic [6:0]    hist_next;
   cal_pkg::cal_t cal_reg;
   cal_pkg::cal_t cal_next;
   logic [4:0]    since_reg;
   logic [4:0]    since_next;
   logic          strict_reg;
   logic          strict_next;
   logic          due;
   logic          mw;
   logic          mw_one;

   // selects in flight are dropped on a mode write, as the gap forbids them
   always_comb
   begin
      due = (cal_reg == 3'h0) ? !cs_b : hist_reg[cal_reg - 3'h1];
      mw = due && (cmd == `CMD_MODE_WRITE);
      mw_one = mw && ({group, bank} == 4'h1);
      hist_next = mw ? 7'h00 : {hist_reg[5:0], !cs_b};
      cal_next = mw_one ? addr[`CAL_LSB +: `CAL_W] : cal_reg;
      since_next = mw ? 5'h01 : since_reg + {4'h0, since_reg != 5'h1f};
      strict_next = mw ? (cal_reg != 3'h0 || cal_next != 3'h0) : strict_reg;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hist_reg <= 7'h00;
         cal_reg <= 3'h0;
         since_reg <= 5'h1f;
         strict_reg <= 1'b0;
      end
      else
      begin
         hist_reg <= hist_next;
         cal_reg <= cal_next;
         since_reg <= since_next;
         strict_reg <= strict_next;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_cmd_only_due: assert property (
      cmd != `CMD_DESELECT |-> due)
      else $error("command on bus with no select due");
   a_due_has_cmd: assert property (
      due |-> cmd != `CMD_DESELECT)
      else $error("select due but no command on bus");
   a_cmd_one_cycle: assert property (
      cmd != `CMD_DESELECT |=> cmd == `CMD_DESELECT)
      else $error("command held longer than one cycle");
   a_select_single: assert property (
      !cs_b |=> cs_b)
      else $error("select low two cycles running");
   a_cmd_select_high: assert property (
      due && cal_reg != 3'h0 |-> cs_b)
      else $error("delayed command sent with select low");
   a_zero_same_cycle: assert property (
      cal_reg == 3'h0 && !cs_b |-> cmd != `CMD_DESELECT)
      else $error("zero latency command not with its select");
   a_write_update_gap: assert property (
      due |-> int'(since_reg) >= UPD + int'(cal_reg))
      else $error("command too soon after mode write");
   a_write_cycle_gap: assert property (
      mw |-> int'(since_reg) >= (strict_reg ? UPD + int'(cal_reg) : MRD))
      else $error("mode writes spaced too closely");
endmodule // cal_link_monitor

// ### testbench/tb_cs_to_cmd_addr_latency_frontend.sv
// bench joining controller and device ends across the command link
// assumes one 200 MHz clock; stimulus enters at the user port only
`timescale 1ns/1ps
`include "cal_regs.svh"
module tb_cs_to_cmd_addr_latency_frontend;
   typedef struct {
      cal_pkg::cmd_t  c;
      cal_pkg::addr_t a;
      logic [3:0]     s;
      logic           r;
      int             lat;
   } exp_item_t;
   localparam int CAL_ON = (`CS_TO_CMD_DELAY_TIME_PS + `CLK_PERIOD_PS - 1)
      / `CLK_PERIOD_PS;
   logic           clock = 1'b0;
   logic           rst_b = 1'b0;
   logic           req_valid = 1'b0;
   cal_pkg::cmd_t  req_cmd = `CMD_DESELECT;
   cal_pkg::addr_t req_addr = 17'h00000;
   logic [3:0]     req_sel = 4'h0;
   logic           req_cal_on = 1'b0;
   logic           req_odt = 1'b0;
   logic           req_ready, cmd_valid, rx_enable, cal_active, odt_out;
   logic           read_burst_of_eight;
   cal_pkg::cmd_t  cmd_out;
   cal_pkg::addr_t addr_out;
   logic [3:0]     mode_sel_out;
   cal_pkg::cal_t  cal_value, cal_in_use;
   logic [1:0]     burst_field;
   int             mismatches = 0, checks_done = 0, cyc = 0, tests = 0;
   int             cs_q[$];
   exp_item_t      exp_q[$];
   cal_pkg::cal_t  exp_cal = 3'h0;
   logic [1:0]     exp_burst = 2'h0;
   logic           odt_prev = 1'b0;

   cal_link_if link();
   cal_device u_cal_device (.clock(clock), .rst_b(rst_b), .link(link),
      .cmd_valid(cmd_valid), .cmd_out(cmd_out), .addr_out(addr_out),
      .mode_sel_out(mode_sel_out), .rx_enable(rx_enable),
      .cal_value(cal_value), .cal_active(cal_active),
      .burst_field(burst_field), .odt_out(odt_out),
      .read_burst_of_eight(read_burst_of_eight));
   cal_controller u_cal_controller (.clock(clock), .rst_b(rst_b),
      .link(link), .req_valid(req_valid), .req_cmd(req_cmd),
      .req_addr(req_addr), .req_sel(req_sel), .req_cal_on(req_cal_on),
      .req_odt(req_odt), .req_ready(req_ready), .cal_in_use(cal_in_use));
   cal_link_monitor u_monitor (.clock(clock), .rst_b(rst_b),
      .cs_b(link.cs_b), .cmd(link.cmd), .addr(link.addr),
      .bank(link.bank), .group(link.group), .odt(link.odt));

   always #2.5 clock = ~clock;

   task automatic check(input string what, input logic [16:0] seen,
                        input logic [16:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // pairs each captured command with its select, in order
   always @(posedge clock)
   begin
      exp_item_t e;
      int        t;
      if (rst_b === 1'b1)
      begin
         cyc++;
         check("termination", 17'(odt_out), 17'(odt_prev));
         odt_prev = link.odt;
         if (cmd_valid === 1'b1)
         begin
            t = -99;
            if (cs_q.size() > 0)
               t = cs_q.pop_front();
            if (exp_q.size() > 0)
               e = exp_q.pop_front();
            else
               e = '{default: 0};
            check("latency", 17'(cyc - t), 17'(e.lat + 1));
            check("command", 17'(cmd_out), 17'(e.c));
            check("address", addr_out, e.a);
            check("select", 17'(mode_sel_out), 17'(e.s));
            check("burst", 17'(read_burst_of_eight), 17'(e.r));
         end
         if (cs_q.size() > 0)
            check("receivers on", 17'(rx_enable), 17'h1);
         if (link.cs_b === 1'b0)
            cs_q.push_back(cyc);
      end
   end

   task automatic issue(input cal_pkg::cmd_t c, input cal_pkg::addr_t a,
                        input logic [3:0] s, input logic on, input logic o);
      exp_item_t e;
      int        n;
      e.c = c;
      e.a = a;
      e.s = s;
      e.lat = exp_cal;
      e.r = (c == `CMD_READ) && (exp_burst == `BL_FIXED8 ||
         (exp_burst == `BL_ON_THE_FLY && a[`BL_OTF_BIT]));
      if (c == `CMD_MODE_WRITE && s == 4'h1)
      begin
         exp_cal = on ? cal_pkg::cal_t'(CAL_ON) : 3'h0;
         e.a[`CAL_LSB +: `CAL_W] = exp_cal;
      end
      if (c == `CMD_MODE_WRITE && s == 4'h0)
         exp_burst = a[`BL_LSB +: `BL_W];
      exp_q.push_back(e);
      for (n = 0; n < 60 && req_ready !== 1'b1; n++) @(posedge clock);
      @(posedge clock);
      req_valid <= 1'b1;
      req_cmd <= c;
      req_addr <= a;
      req_sel <= s;
      req_cal_on <= on;
      req_odt <= o;
      for (n = 0; n < 60 && req_ready !== 1'b0; n++) @(posedge clock) #1;
      @(posedge clock);
      req_valid <= 1'b0;
      for (n = 0; n < 60 && exp_q.size() > 0; n++) @(posedge clock);
      repeat (4) @(posedge clock);
      #1;
      check("receivers off", 17'(rx_enable), 17'h0);
      check("latency value", 17'(cal_value), 17'(exp_cal));
      check("latency in use", 17'(cal_in_use), 17'(exp_cal));
      check("latency active", 17'(cal_active), 17'(exp_cal != 0));
      check("burst field", 17'(burst_field), 17'(exp_burst));
      tests++;
      $display("test %0d done", tests);
   endtask

   initial
   begin
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      issue(`CMD_READ, 17'h01000, 4'h2, 1'b0, 1'b1);
      issue(`CMD_MODE_WRITE, 17'h00001, 4'h0, 1'b0, 1'b0);
      issue(`CMD_READ, 17'h01000, 4'h3, 1'b0, 1'b0);
      issue(`CMD_READ, 17'h00000, 4'h0, 1'b0, 1'b1);
      issue(`CMD_MODE_WRITE, 17'h00000, 4'h1, 1'b1, 1'b1);
      issue(`CMD_READ, 17'h01000, 4'h2, 1'b0, 1'b0);
      issue(4'hc, 17'h001c0, 4'h1, 1'b0, 1'b1);
      issue(`CMD_MODE_WRITE, 17'h00002, 4'h0, 1'b1, 1'b0);
      issue(`CMD_READ, 17'h01000, 4'h1, 1'b0, 1'b1);
      issue(`CMD_MODE_WRITE, 17'h001c3, 4'h2, 1'b0, 1'b0);
      issue(`CMD_MODE_WRITE, 17'h00000, 4'h1, 1'b0, 1'b0);
      issue(`CMD_READ, 17'h00000, 4'h0, 1'b0, 1'b1);
      test_done();
   end

   // the sequence needs well under 1000 cycles; this allows 20000
   initial
   begin
      #100000;
      mismatches++;
      test_done();
   end
endmodule // tb_cs_to_cmd_addr_latency_frontend
